// ---- hdl/pcr_pkg.sv ----
// Purpose: Constants for the PLL command and interrupt-clear register group.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Printed offsets are not multiples of four, so they are indices.
package pcr_pkg;
	// ****************************************************************
	// Register indices and address width
	// ****************************************************************
	localparam logic [11:0] PCR_IDX_LOOP_MODE = 12'ha01;
	localparam logic [11:0] PCR_IDX_DIST_SYNC = 12'ha02;
	localparam logic [11:0] PCR_IDX_RESET_CMD = 12'ha03;
	localparam logic [11:0] PCR_IDX_IRQ_CLR_A = 12'ha04;
	localparam logic [11:0] PCR_IDX_IRQ_CLR_B = 12'ha05;
	localparam logic [11:0] PCR_IDX_WDOG_PERIOD = 12'ha10;
	localparam int PCR_ADDR_W = 14;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PCR_MANREF_LSB = 0;
	localparam int PCR_SWMODE_LSB = 2;
	localparam int PCR_SYNC_BIT = 1;
	localparam int PCR_RST_LF_BIT = 6;
	localparam int PCR_RST_RF_BIT = 5;
	localparam int PCR_RST_AS_BIT = 3;
	localparam int PCR_RST_TW_BIT = 2;
	localparam int PCR_RST_IRQ_BIT = 1;
	localparam int PCR_RST_WD_BIT = 0;
	localparam logic [7:0] PCR_LOOP_MASK = 8'h7f;
	localparam logic [7:0] PCR_RST_MASK = 8'h6f;
	localparam logic [7:0] PCR_CLR_A_MASK = 8'h3f;
	localparam logic [7:0] PCR_CLR_B_MASK = 8'h1f;
	localparam int PCR_WD_FLAG_BIT = 2;
	// ****************************************************************
	// Reset values and modes
	// ****************************************************************
	localparam logic [7:0] PCR_LOOP_RST = 8'h00;
	localparam logic [7:0] PCR_SYNC_RST = 8'h00;
	localparam logic [15:0] PCR_WDOG_PERIOD_RST = 16'h0000;
	localparam int PCR_WDOG_TICK_US = 1000;
	localparam int PCR_CLK_MHZ = 50;
	localparam int PCR_WDOG_TICK_CYC = PCR_WDOG_TICK_US * PCR_CLK_MHZ;
	typedef enum logic [2:0] {
		PCR_SW_AUTO_REV = 3'h0,
		PCR_SW_AUTO_NONREV = 3'h1,
		PCR_SW_MAN_FALLBACK = 3'h2,
		PCR_SW_MAN_HOLD = 3'h3,
		PCR_SW_FULL_MAN = 3'h4
	} pcr_swmode_t;
	typedef enum logic [1:0] {
		PCR_REF_A = 2'h0,
		PCR_REF_B = 2'h1,
		PCR_REF_C = 2'h2,
		PCR_REF_D = 2'h3
	} pcr_ref_t;
	typedef enum logic [1:0] {
		PCR_WD_IDLE = 2'b01,
		PCR_WD_RUN = 2'b10
	} pcr_wd_state_t;
endpackage : pcr_pkg

// ---- hdl/pcr_cmd_if.sv ----
// Purpose: Carries one-shot commands from the register bank to the timer.
// Assumes: Single clock domain.
// Notes: Restart is a one-cycle pulse; period is a level.
`timescale 1ns/1ps
`default_nettype none
interface pcr_cmd_if;
	logic restart;
	logic [15:0] period;
	logic timeout;
	modport bank (output restart, output period, input timeout);
	modport timer (input restart, input period, output timeout);
endinterface : pcr_cmd_if
`default_nettype wire

// ---- hdl/pcr_wdog.sv ----
// Purpose: Watchdog timer that software restarts by a command strobe.
// Assumes: Period counts ticks; a zero period disables the timer.
// Notes: Timeout is a one-cycle pulse per expiry.
`timescale 1ns/1ps
`default_nettype none
module pcr_wdog
	import pcr_pkg::*;
#(
	parameter int TICK_CYC = PCR_WDOG_TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	pcr_cmd_if.timer cmd
);
	logic [31:0] tick_cnt_ff;
	logic [15:0] per_cnt_ff;
	logic timeout_ff;
	pcr_wd_state_t state_ff;
	pcr_wd_state_t nxt_state;
	wire tick_end = (tick_cnt_ff == 32'(TICK_CYC - 1));
	wire per_end = tick_end && (per_cnt_ff == cmd.period - 16'h0001);
	assign cmd.timeout = timeout_ff;

	// A restart always begins a fresh cycle, expired or not.
	always_comb begin
		case (state_ff)
			PCR_WD_IDLE: nxt_state = (cmd.period != 16'h0000) ?
				PCR_WD_RUN : PCR_WD_IDLE;
			PCR_WD_RUN: nxt_state = (cmd.period == 16'h0000) ?
				PCR_WD_IDLE : PCR_WD_RUN;
			default: nxt_state = PCR_WD_IDLE;
		endcase
	end

	// Counters restart from zero on a restart, so no timeout escapes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= PCR_WD_IDLE;
			tick_cnt_ff <= 32'h0;
			per_cnt_ff <= 16'h0;
			timeout_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (cmd.restart || state_ff != PCR_WD_RUN) begin
				tick_cnt_ff <= 32'h0;
				per_cnt_ff <= 16'h0;
				timeout_ff <= 1'b0;
			end else begin
				tick_cnt_ff <= tick_end ? 32'h0 : tick_cnt_ff + 32'h1;
				if (per_end) begin
					per_cnt_ff <= 16'h0;
				end else if (tick_end) begin
					per_cnt_ff <= per_cnt_ff + 16'h1;
				end
				timeout_ff <= per_end;
			end
		end
	end
endmodule : pcr_wdog
`default_nettype wire

// ---- hdl/pcr_regs.sv ----
// Purpose: Command and interrupt-clear register group of a clock translator.
// Assumes: APB slave, zero wait states, 32-bit data, word index = paddr/4.
// Notes: All command bits except soft sync are write-one strobes and read back as zero.
//
// How it works
// - Manual reference field drives selection only in modes 010, 011, 100.
// - Manual field 00 picks A, 01 B, 10 C, 11 D; reset 00.
// - Writing one to soft sync starts distribution sync; resets to zero.
// - Outputs stall while sync bit is one; restart on its fall.
// - Every reset-command bit clears itself; each is a one-shot strobe.
// - Bit 6 of reset commands flushes the loop filter.
// - Bit 5 of reset commands flushes the rate filter.
// - Bit 3 resets the automatic synchronisation logic.
// - Bit 2 flushes the tuning-word history used by holdover.
// - Bit 1 clears all interrupt flags, like every clear bit at once.
// - Bit 0 restarts the watchdog; after expiry a new cycle begins.
// - Restart before expiry restarts from zero with no timeout event.
// - Writing one to a clear bit drops that flag; zero does nothing.
// - Clear registers mirror monitor layout and clear themselves.
// - First clear register: bit 5 clock unlocked, bit 4 locked.
// - Bits 3..0: output PLL unlocked, locked, cal done, cal started.
// - Second clear register: bit 4 pin-program end, bit 3 sync.
// - Bits 2..0: watchdog, EEPROM fault, EEPROM complete.
// - Switchover mode codes 000 to 100 as listed; others unused.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs
	import pcr_pkg::*;
#(
	parameter int TICK_CYC = PCR_WDOG_TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] ref_auto_sel,
	input wire logic [5:0] irq_set_a,
	input wire logic [4:0] irq_set_b,
	output logic [3:0] ref_active,
	output logic [2:0] switchover_mode,
	output logic user_holdover,
	output logic user_free_run,
	output logic dist_stall,
	output logic dist_restart,
	output logic loop_filter_flush,
	output logic rate_filter_flush,
	output logic auto_sync_reset,
	output logic tuning_word_history_flush,
	output logic [5:0] irq_flags_a,
	output logic [4:0] irq_flags_b
);
	// ****************************************************************
	// Bus decode
	// ****************************************************************
	function automatic logic hit(input logic [PCR_ADDR_W-1:0] a,
			input logic [11:0] idx);
		hit = (a[PCR_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
	endfunction : hit

	pcr_cmd_if cmd();

	logic [7:0] loop_ff;
	logic [7:0] sync_ff;
	logic [15:0] wdog_per_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic pready_ff;
	logic [3:0] ref_active_ff;
	logic stall_ff;
	logic restart_ff;
	logic lf_ff;
	logic rf_ff;
	logic as_ff;
	logic tw_ff;
	logic [5:0] flags_a_ff;
	logic [4:0] flags_b_ff;

	// The access phase is the single cycle a write takes effect.
	wire acc = psel && penable;
	wire wr = acc && pwrite && pstrb[0];
	wire hit_loop = hit(paddr, PCR_IDX_LOOP_MODE);
	wire hit_sync = hit(paddr, PCR_IDX_DIST_SYNC);
	wire hit_rst = hit(paddr, PCR_IDX_RESET_CMD);
	wire hit_ca = hit(paddr, PCR_IDX_IRQ_CLR_A);
	wire hit_cb = hit(paddr, PCR_IDX_IRQ_CLR_B);
	wire hit_wd = hit(paddr, PCR_IDX_WDOG_PERIOD);
	wire mapped = hit_loop || hit_sync || hit_rst || hit_ca || hit_cb ||
		hit_wd;
	wire [7:0] wbyte = pwdata[7:0];

	// ****************************************************************
	// Command strobes
	// ****************************************************************
	// Strobes are decoded straight from the write and never stored.
	wire [7:0] rst_cmd = (wr && hit_rst) ? (wbyte & PCR_RST_MASK) :
		8'h00;
	wire clr_all = rst_cmd[PCR_RST_IRQ_BIT];
	wire [5:0] clr_a = ((wr && hit_ca) ? wbyte[5:0] & PCR_CLR_A_MASK[5:0] :
		6'h00) | {6{clr_all}};
	wire [4:0] clr_b = ((wr && hit_cb) ? wbyte[4:0] & PCR_CLR_B_MASK[4:0] :
		5'h00) | {5{clr_all}};
	wire [4:0] set_b = irq_set_b | ({4'h0, cmd.timeout} << PCR_WD_FLAG_BIT);

	// ****************************************************************
	// Reference selection
	// ****************************************************************
	wire [2:0] swmode = loop_ff[PCR_SWMODE_LSB +: 3];
	wire manual = (swmode == PCR_SW_MAN_FALLBACK) ||
		(swmode == PCR_SW_MAN_HOLD) ||
		(swmode == PCR_SW_FULL_MAN);
	wire [1:0] manref = loop_ff[PCR_MANREF_LSB +: 2];
	wire [3:0] man_onehot = 4'h1 << manref;
	wire [3:0] nxt_ref_active = manual ? man_onehot : ref_auto_sel;
	wire sync_bit = sync_ff[PCR_SYNC_BIT];
	wire [7:0] nxt_sync = (wr && hit_sync) ?
		(wbyte & (8'h01 << PCR_SYNC_BIT)) : sync_ff;

	// Read mux; command registers read zero since they hold nothing.
	wire [31:0] nxt_prdata = hit_loop ? {24'h0, loop_ff} :
		hit_sync ? {24'h0, sync_ff} :
		hit_wd ? {16'h0, wdog_per_ff} : 32'h0;

	assign cmd.restart = rst_cmd[PCR_RST_WD_BIT];
	assign cmd.period = wdog_per_ff;

	// ****************************************************************
	// Stored settings
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_ff <= PCR_LOOP_RST;
			sync_ff <= PCR_SYNC_RST;
			wdog_per_ff <= PCR_WDOG_PERIOD_RST;
		end else begin
			if (wr && hit_loop) begin
				loop_ff <= wbyte & PCR_LOOP_MASK;
			end
			sync_ff <= nxt_sync;
			if (wr && hit_wd && pstrb[1]) begin
				wdog_per_ff <= pwdata[15:0];
			end else if (wr && hit_wd) begin
				wdog_per_ff <= {wdog_per_ff[15:8], wbyte};
			end
		end
	end

	// Bus answer is registered; every access completes without wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
			pready_ff <= 1'b1;
		end else begin
			prdata_ff <= (psel && !penable && !pwrite) ? nxt_prdata :
				prdata_ff;
			pslverr_ff <= psel && !penable && !mapped;
			pready_ff <= 1'b1;
		end
	end

	// Sync restart fires on the fall of the stall level only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_ff <= 1'b0;
			restart_ff <= 1'b0;
			ref_active_ff <= 4'h1;
		end else begin
			stall_ff <= nxt_sync[PCR_SYNC_BIT];
			restart_ff <= sync_bit && !nxt_sync[PCR_SYNC_BIT];
			ref_active_ff <= nxt_ref_active;
		end
	end

	// Flush pulses last one cycle per written one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_ff <= 1'b0;
			rf_ff <= 1'b0;
			as_ff <= 1'b0;
			tw_ff <= 1'b0;
		end else begin
			lf_ff <= rst_cmd[PCR_RST_LF_BIT];
			rf_ff <= rst_cmd[PCR_RST_RF_BIT];
			as_ff <= rst_cmd[PCR_RST_AS_BIT];
			tw_ff <= rst_cmd[PCR_RST_TW_BIT];
		end
	end

	// Set wins over clear so an event in the clearing cycle survives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_a_ff <= 6'h00;
			flags_b_ff <= 5'h00;
		end else begin
			flags_a_ff <= irq_set_a | (flags_a_ff & ~clr_a);
			flags_b_ff <= set_b | (flags_b_ff & ~clr_b);
		end
	end

	pcr_wdog #(
		.TICK_CYC(TICK_CYC)
	) u_wdog (
		.pclk(pclk),
		.presetn(presetn),
		.cmd(cmd.timer)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ref_active = ref_active_ff;
	assign switchover_mode = loop_ff[PCR_SWMODE_LSB +: 3];
	assign user_holdover = loop_ff[6];
	assign user_free_run = loop_ff[5];
	assign dist_stall = stall_ff;
	assign dist_restart = restart_ff;
	assign loop_filter_flush = lf_ff;
	assign rate_filter_flush = rf_ff;
	assign auto_sync_reset = as_ff;
	assign tuning_word_history_flush = tw_ff;
	assign irq_flags_a = flags_a_ff;
	assign irq_flags_b = flags_b_ff;
endmodule : pcr_regs
`default_nettype wire

// ---- verif/pcr_regs_props.sv ----
// Purpose: Port-level checks of the command and clear register group.
// Assumes: Zero wait state APB; pulses follow the write edge by one cycle.
// Notes: The watchdog flag is judged by the bench, not here.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_props
	import pcr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic [5:0] irq_set_a,
	input wire logic [2:0] switchover_mode,
	input wire logic dist_stall,
	input wire logic dist_restart,
	input wire logic loop_filter_flush,
	input wire logic tuning_word_history_flush,
	input wire logic [5:0] irq_flags_a
);
	// ************************************************************
	// Decode
	// ************************************************************
	// Writes land only with lane zero enabled, so the strobe is in it.
	wire logic wr = psel & penable & pwrite & pstrb[0];
	wire logic w_loop = wr & (paddr == {PCR_IDX_LOOP_MODE, 2'b00});
	wire logic w_sync = wr & (paddr == {PCR_IDX_DIST_SYNC, 2'b00});
	wire logic w_rst = wr & (paddr == {PCR_IDX_RESET_CMD, 2'b00});
	wire logic w_ca = wr & (paddr == {PCR_IDX_IRQ_CLR_A, 2'b00});
	wire logic r_cmd = psel & ~penable & ~pwrite & (paddr[13:2] >= 12'ha03)
		& (paddr[13:2] <= 12'ha05) & (paddr[1:0] == 2'h0);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ************************************************************
	// Properties
	// ************************************************************
	property p_lf; w_rst && pwdata[6] |=> loop_filter_flush; endproperty
	a_lf: assert property (p_lf) else $error("no loop flush");
	property p_tw; w_rst && pwdata[2] |=> tuning_word_history_flush;
	endproperty
	a_tw: assert property (p_tw) else $error("no history flush");
	property p_one; loop_filter_flush |-> $past(w_rst && pwdata[6]);
	endproperty
	a_one: assert property (p_one) else $error("stray flush");
	property p_all; w_rst && pwdata[1] && !(|irq_set_a) |=>
		irq_flags_a == 6'h00; endproperty
	a_all: assert property (p_all) else $error("flags kept");
	property p_clr; w_ca && !(|irq_set_a) |=> irq_flags_a ==
		($past(irq_flags_a) & ~$past(pwdata[5:0])); endproperty
	a_clr: assert property (p_clr) else $error("bad clear");
	property p_set; irq_set_a != 6'h00 |=> (irq_flags_a & $past(irq_set_a))
		== $past(irq_set_a); endproperty
	a_set: assert property (p_set) else $error("event lost");
	property p_stall; w_sync |=> dist_stall == $past(pwdata[1]); endproperty
	a_stall: assert property (p_stall) else $error("bad stall");
	property p_rest; $fell(dist_stall) |-> ##[0:1] dist_restart; endproperty
	a_rest: assert property (p_rest) else $error("no restart");
	property p_mode; w_loop |=> switchover_mode == $past(pwdata[4:2]);
	endproperty
	a_mode: assert property (p_mode) else $error("bad mode");
	property p_rdz; r_cmd |=> prdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("command reads set");
endmodule : pcr_regs_props
bind pcr_regs pcr_regs_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .irq_set_a(irq_set_a),
	.switchover_mode(switchover_mode), .dist_stall(dist_stall),
	.dist_restart(dist_restart), .loop_filter_flush(loop_filter_flush),
	.tuning_word_history_flush(tuning_word_history_flush),
	.irq_flags_a(irq_flags_a));
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the command and clear register group.
// Assumes: Zero wait state slave; watchdog tick shortened to 4 cycles.
// Notes: Each scenario is one task that drives and judges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pcr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, q, cnt;
	logic [3:0] pstrb, ref_auto_sel, ref_active;
	logic [5:0] irq_set_a, irq_flags_a;
	logic [4:0] irq_set_b, irq_flags_b;
	logic [2:0] switchover_mode;
	logic hold, frun, dist_stall, dist_restart, lf, rf, asr, tw;
	int n_errors, checks;
	localparam logic [13:0] A_LOOP = 14'h2804;
	localparam logic [13:0] A_SYNC = 14'h2808;
	localparam logic [13:0] A_RST = 14'h280c;
	localparam logic [13:0] A_CA = 14'h2810;
	localparam logic [13:0] A_CB = 14'h2814;
	localparam logic [13:0] A_WD = 14'h2840;
	pcr_regs #(.TICK_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_auto_sel(ref_auto_sel),
		.irq_set_a(irq_set_a), .irq_set_b(irq_set_b),
		.ref_active(ref_active), .switchover_mode(switchover_mode),
		.user_holdover(hold), .user_free_run(frun),
		.dist_stall(dist_stall), .dist_restart(dist_restart),
		.loop_filter_flush(lf), .rate_filter_flush(rf),
		.auto_sync_reset(asr), .tuning_word_history_flush(tw),
		.irq_flags_a(irq_flags_a), .irq_flags_b(irq_flags_b));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	// Compare with case equality so an unknown never matches.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high.
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wchk(input logic [13:0] a, input logic [31:0] d,
		input logic [31:0] e);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
		chk({irq_flags_a, irq_flags_b}, e);
	endtask : wchk
	task set_all;
		@(posedge pclk);
		irq_set_a <= 6'h3f;
		irq_set_b <= 5'h1f;
		@(posedge pclk);
		irq_set_a <= 6'h00;
		irq_set_b <= 5'h00;
	endtask : set_all
	task summarize;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset;
		chk({dist_stall, irq_flags_a, irq_flags_b, ref_active}, 32'h1);
		chk({pready, pslverr, lf, rf, asr, tw, hold, frun, dist_restart,
			switchover_mode}, 32'h800);
		chk(prdata, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, A_LOOP, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, A_SYNC, 32'h0);
		chk(q, 32'h0);
		$display("reset test done");
	endtask : t_reset
	// Every mode code, unused ones too, with every manual code.
	task t_manual;
		for (int m = 0; m < 8; m++) begin
			for (int r = 0; r < 4; r++) begin
				ref_auto_sel <= 4'h8 >> r;
				apb(1'b1, A_LOOP, 32'(m * 4 + r));
				repeat (3) @(posedge pclk);
				chk(ref_active, (m > 1 && m < 5) ? 32'h1 << r : 32'h8 >> r);
				chk(switchover_mode, 32'(m));
			end
		end
		apb(1'b1, A_LOOP, 32'h20);
		repeat (2) @(posedge pclk);
		chk({hold, frun}, 32'h1);
		apb(1'b1, A_LOOP, 32'h5f);
		repeat (2) @(posedge pclk);
		chk({hold, frun}, 32'h2);
		$display("manual test done");
	endtask : t_manual
	task t_sync;
		apb(1'b1, A_SYNC, 32'h2);
		repeat (2) @(posedge pclk);
		chk(dist_stall, 32'h1);
		apb(1'b0, A_SYNC, 32'h0);
		chk(q, 32'h2);
		cnt = 0;
		apb(1'b1, A_SYNC, 32'h0);
		repeat (4) @(posedge pclk) cnt += dist_restart;
		chk({cnt[30:0], dist_stall}, 32'h2);
		$display("sync test done");
	endtask : t_sync
	// Counts each flush pulse per bytes so a double pulse shows.
	task t_strobe;
		for (int b = 0; b < 8; b++) begin
			cnt = 0;
			apb(1'b1, A_RST, 32'h1 << b);
			repeat (4) @(posedge pclk) cnt += {8'(lf), 8'(rf), 8'(asr), 8'(tw)};
			chk(cnt, {8'(b == 6), 8'(b == 5), 8'(b == 3), 8'(b == 2)});
		end
		apb(1'b0, A_RST, 32'h0);
		chk(q, 32'h0);
		$display("strobe test done");
	endtask : t_strobe
	task t_irq;
		set_all;
		wchk(A_CA, 32'h0, 32'h7ff);
		wchk(A_CA, 32'h21, 32'h3df);
		wchk(A_CB, 32'h18, 32'h3c7);
		wchk(A_CB, 32'h07, 32'h3c0);
		wchk(A_CA, 32'h1e, 32'h0);
		// An event in the clearing cycle must survive the clear.
		fork
			apb(1'b1, A_CA, 32'h3f);
			begin
				repeat (2) @(posedge pclk);
				irq_set_a <= 6'h01;
				@(posedge pclk);
				irq_set_a <= 6'h00;
			end
		join
		repeat (2) @(posedge pclk);
		chk(irq_flags_a, 32'h1);
		apb(1'b0, A_CB, 32'h0);
		chk(q, 32'h0);
		set_all;
		wchk(A_RST, 32'h2, 32'h0);
		$display("irq test done");
	endtask : t_irq
	// Restarts every three cycles hold off a twelve-cycle period.
	task t_wdog;
		apb(1'b1, A_WD, 32'h3);
		repeat (6) apb(1'b1, A_RST, 32'h1);
		chk(irq_flags_b[PCR_WD_FLAG_BIT], 32'h0);
		repeat (30) @(posedge pclk);
		chk(irq_flags_b[PCR_WD_FLAG_BIT], 32'h1);
		// Restart after expiry; the old cycle would have struck soon after.
		apb(1'b1, A_RST, 32'h1);
		wchk(A_CB, 32'h4, 32'h0);
		repeat (8) @(posedge pclk);
		chk(irq_flags_b[PCR_WD_FLAG_BIT], 32'h0);
		@(posedge pclk);
		chk(irq_flags_b[PCR_WD_FLAG_BIT], 32'h1);
		apb(1'b1, A_WD, 32'h0);
		$display("watchdog test done");
	endtask : t_wdog
	task t_bad;
		apb(1'b1, 14'h2805, 32'h7f);
		chk(err, 32'h1);
		apb(1'b0, 14'h2818, 32'h0);
		chk({q[30:0], err}, 32'h1);
		apb(1'b0, A_LOOP, 32'h0);
		chk({q[30:0], err}, 32'hbe);
		$display("unmapped test done");
	endtask : t_bad
	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		summarize();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{irq_set_a, irq_set_b, ref_auto_sel} = '0;
		pstrb = 4'hf;
		repeat (6) @(posedge pclk);
		t_reset();
		t_manual();
		t_sync();
		t_strobe();
		t_irq();
		t_wdog();
		t_bad();
		summarize();
	end
endmodule : testbench
`default_nettype wire
